// >>> inc/ivc_pkg.sv
package ivc_pkg;

  // Control-port byte addresses of the input-path volume registers.
  localparam int          ADDR_W         = 20;
  localparam logic [19:0] UPDATE_OFS     = 20'h0_4014;
  localparam logic [19:0] GAIN_OFS [4]   = '{20'h0_4028, 20'h0_4048, 20'h0_4068, 20'h0_4088};
  localparam logic [19:0] P2R_SOURCE_OFS = 20'h0_4084;
  localparam logic [19:0] HPF_CFG_OFS    = 20'h0_4244;
  localparam logic [19:0] RAMP_CFG_OFS   = 20'h0_4248;
  localparam logic [19:0] TRIGGER_OFS    = 20'h1_9000;

  // Field positions inside those registers.
  localparam int UPDATE_BIT    = 29;
  localparam int MUTE_BIT      = 28;
  localparam int VOL_LSB       = 16;
  localparam int PGA_LSB       = 1;
  localparam int SRC_LSB       = 28;
  localparam int HPF_ON_BIT    = 2;
  localparam int LOW_POWER_BIT = 0;
  localparam int CORNER_LSB    = 0;
  localparam int RISE_LSB      = 0;
  localparam int FALL_LSB      = 4;
  localparam int TRIG_BIT      = 0;

  // Values after reset and field limits.
  localparam logic       MUTE_RST    = 1'b1;
  localparam logic [7:0] VOL_RST     = 8'h80;
  localparam logic [7:0] VOL_MAX     = 8'hBF;
  localparam logic [6:0] PGA_RST     = 7'h40;
  localparam logic [6:0] PGA_MID_MIN = 7'h46;
  localparam logic [1:0] SRC_RST     = 2'h0;
  localparam logic [2:0] CORNER_RST  = 3'h2;
  localparam logic [2:0] RAMP_RST    = 3'h2;

  // Clock and ramp timing; a ramp covers 6 dB in 48 steps of 0.125 dB.
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned STEP_PER_6DB  = 48;
  localparam int unsigned RAMP_0P5MS_US = 500;
  localparam int unsigned RAMP_1MS_US   = 1000;
  localparam int unsigned RAMP_2MS_US   = 2000;
  localparam int unsigned RAMP_4MS_US   = 4000;
  localparam int unsigned RAMP_8MS_US   = 8000;
  localparam int unsigned RAMP_15MS_US  = 15000;
  localparam int unsigned RAMP_30MS_US  = 30000;
  localparam int unsigned STEP_DIV      = STEP_PER_6DB * CLK_PERIOD_NS;
  localparam int unsigned STEP_CYC_0P5MS = RAMP_0P5MS_US * 1000 / STEP_DIV;
  localparam int unsigned STEP_CYC_1MS   = RAMP_1MS_US * 1000 / STEP_DIV;
  localparam int unsigned STEP_CYC_2MS   = RAMP_2MS_US * 1000 / STEP_DIV;
  localparam int unsigned STEP_CYC_4MS   = RAMP_4MS_US * 1000 / STEP_DIV;
  localparam int unsigned STEP_CYC_8MS   = RAMP_8MS_US * 1000 / STEP_DIV;
  localparam int unsigned STEP_CYC_15MS  = RAMP_15MS_US * 1000 / STEP_DIV;
  localparam int unsigned STEP_CYC_30MS  = RAMP_30MS_US * 1000 / STEP_DIV;

  // Gain arithmetic: gain in eighths of a dB, 512 is unity, offset aligns octaves.
  localparam logic [9:0] UNITY_GAIN = 10'h200;
  localparam logic [10:0] ALIGN_OFS = 11'h010;
  localparam int          FRAC_SHIFT = 40;
  localparam logic [15:0] DB_MANT [6] = '{16'h4000, 16'h47CF, 16'h5092, 16'h5A67,
                                          16'h656F, 16'h71CF};
  localparam logic [15:0] EIGHTH_MANT [8] = '{16'h8000, 16'h81DC, 16'h83BD, 16'h85A6,
                                              16'h8796, 16'h898D, 16'h8B8B, 16'h8D91};

endpackage

// >>> design/ivc_gain_ramp.sv
`timescale 1ns/1ps
`default_nettype none

module ivc_gain_ramp (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Target and shared step timing.
  input  wire logic [9:0] targetGain,
  input  wire logic       mute,
  input  wire logic       riseTick,
  input  wire logic       fallTick,
  input  wire logic       riseNow,
  input  wire logic       fallNow,
  // Applied gain in eighths of a dB.
  output logic      [9:0] gain_r,
  output logic            silent_r
);

  logic [9:0] effTarget;
  logic [9:0] gain_nxt;
  logic       silent_nxt;

  // A muted channel heads for the floor, so mute fades out like a gain cut.
  always_comb begin
    effTarget  = mute ? 10'h000 : targetGain;
    gain_nxt   = gain_r;
    if (gain_r < effTarget) begin
      if (riseNow) begin
        gain_nxt = effTarget;
      end else if (riseTick) begin
        gain_nxt = gain_r + 10'h001;
      end
    end else if (gain_r > effTarget) begin
      if (fallNow) begin
        gain_nxt = effTarget;
      end else if (fallTick) begin
        gain_nxt = gain_r - 10'h001;
      end
    end
    silent_nxt = mute && (gain_nxt == 10'h000);
  end

  // Reset leaves the channel muted at the floor.
  always_ff @(posedge clk) begin
    if (rst) begin
      gain_r   <= 10'h000;
      silent_r <= 1'b1;
    end else begin
      gain_r   <= gain_nxt;
      silent_r <= silent_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_ramp_step;
    !riseNow && !fallNow |=> (gain_r - $past(gain_r) <= 10'h001) ||
                             ($past(gain_r) - gain_r <= 10'h001);
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("gain jumped");

  property p_fall_step;
    mute && fallTick && !fallNow && gain_r != 10'h000 |=> gain_r == $past(gain_r) - 10'h001;
  endproperty
  a_fall_step: assert property (p_fall_step) else $error("mute step missing");

  property p_ramp_done;
    !mute && gain_r != targetGain ##1 gain_r == targetGain;
  endproperty
  c_ramp_done: cover property (p_ramp_done);

endmodule

`default_nettype wire

// >>> design/ivc_input_volume_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Each channel applies digital gain from -64 dB to +31.5 dB in half-dB steps.
// - Mute bit 28 per channel, 1 mutes, resets muted.
// - Volume and mute writes stay pending until update bit 29 is written 1.
// - The update bit is write-only and reads back as zero.
// - Gain increase or unmute ramps at the rise rate, default 1 ms per 6 dB.
// - Gain decrease or mute ramps at the fall rate, same time encoding.
// - Ramps step the applied gain in 0.125 dB increments.
// - Digital paths at unity present -6 dBFS input as full scale.
// - PGA code in bits 7:1, 0x40 is 0 dB, 1 dB per code.
// - Mid-power operation lifts PGA settings of 5 dB or less to 6 dB.
// - Source bits 29:28 pick differential 00 or single-ended 01.
// - Single HPF enable, bit 2 of the source register, resets off.
// - Shared HPF corner field picks 2.5 to 40 Hz, resets to 010.
// - Low-power bit 0 acts only for analog input.
// - Trigger bit rising selects Standard Mode on analog paths, falling selects High-Performance.

module ivc_input_volume_ctrl #(
  parameter int unsigned STEP_CYC_8MS  = ivc_pkg::STEP_CYC_8MS,
  parameter int unsigned STEP_CYC_15MS = ivc_pkg::STEP_CYC_15MS,
  parameter int unsigned STEP_CYC_30MS = ivc_pkg::STEP_CYC_30MS
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port.
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [19:0] regAddr,
  input  wire logic [31:0] regWdata,
  output logic      [31:0] regRdata_r,
  output logic             regRdValid_r,
  // Path configuration from outside this block.
  input  wire logic [1:0]  pathDigital,
  input  wire logic [1:0]  pathMidPower,
  // Sample stream in and out.
  input  wire logic signed [23:0] sampleIn,
  input  wire logic        sampleValid,
  input  wire logic [1:0]  sampleChan,
  output logic signed [23:0] sampleOut_r,
  output logic             sampleOutValid_r,
  output logic      [1:0]  sampleOutChan_r,
  // Applied settings.
  output logic      [39:0] appliedGain,
  output logic      [3:0]  channelSilent,
  output logic      [27:0] analogGain_r,
  output logic      [1:0]  p2rSource_r,
  output logic             p2rHighpassOn_r,
  output logic             p2rLowPower_r,
  output logic      [2:0]  highpassCorner_r,
  output logic      [1:0]  standardMode_r
);

  // Register state.
  logic [3:0] pendMute_r, pendMute_nxt, actMute_r, actMute_nxt;
  logic [7:0] pendVol_r [4], pendVol_nxt [4], actVol_r [4], actVol_nxt [4];
  logic [6:0] pga_r [4], pga_nxt [4];
  logic [1:0] src_r, src_nxt;
  logic       hpfOn_r, hpfOn_nxt, lowPow_r, lowPow_nxt;
  logic [2:0] corner_r, corner_nxt, riseRate_r, riseRate_nxt, fallRate_r, fallRate_nxt;
  logic       trig_r, trig_nxt;
  logic [31:0] rdata_nxt;
  logic       updWr;

  // Volume and mute writes land in the pending copies; the strobe moves them to active.
  always_comb begin
    pendMute_nxt = pendMute_r;
    actMute_nxt  = actMute_r;
    pendVol_nxt  = pendVol_r;
    actVol_nxt   = actVol_r;
    pga_nxt      = pga_r;
    src_nxt      = src_r;
    hpfOn_nxt    = hpfOn_r;
    lowPow_nxt   = lowPow_r;
    corner_nxt   = corner_r;
    riseRate_nxt = riseRate_r;
    fallRate_nxt = fallRate_r;
    trig_nxt     = trig_r;
    updWr = regWrite && (regAddr == ivc_pkg::UPDATE_OFS) && regWdata[ivc_pkg::UPDATE_BIT];
    if (regWrite) begin
      for (int c = 0; c < 4; c++) begin
        if (regAddr == ivc_pkg::GAIN_OFS[c]) begin
          pendMute_nxt[c] = regWdata[ivc_pkg::MUTE_BIT];
          pendVol_nxt[c]  = regWdata[ivc_pkg::VOL_LSB +: 8];
          pga_nxt[c]      = regWdata[ivc_pkg::PGA_LSB +: 7];
        end
      end
      if (regAddr == ivc_pkg::P2R_SOURCE_OFS) begin
        src_nxt    = regWdata[ivc_pkg::SRC_LSB +: 2];
        hpfOn_nxt  = regWdata[ivc_pkg::HPF_ON_BIT];
        lowPow_nxt = regWdata[ivc_pkg::LOW_POWER_BIT];
      end
      if (regAddr == ivc_pkg::HPF_CFG_OFS) begin
        corner_nxt = regWdata[ivc_pkg::CORNER_LSB +: 3];
      end
      if (regAddr == ivc_pkg::RAMP_CFG_OFS) begin
        riseRate_nxt = regWdata[ivc_pkg::RISE_LSB +: 3];
        fallRate_nxt = regWdata[ivc_pkg::FALL_LSB +: 3];
      end
      if (regAddr == ivc_pkg::TRIGGER_OFS) begin
        trig_nxt = regWdata[ivc_pkg::TRIG_BIT];
      end
    end
    if (updWr) begin
      actMute_nxt = pendMute_nxt;
      actVol_nxt  = pendVol_nxt;
    end
  end

  // Reads return the pending copies, which are what software last wrote.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    for (int c = 0; c < 4; c++) begin
      if (regAddr == ivc_pkg::GAIN_OFS[c]) begin
        rdata_nxt[ivc_pkg::MUTE_BIT]     = pendMute_r[c];
        rdata_nxt[ivc_pkg::VOL_LSB +: 8] = pendVol_r[c];
        rdata_nxt[ivc_pkg::PGA_LSB +: 7] = pga_r[c];
      end
    end
    if (regAddr == ivc_pkg::P2R_SOURCE_OFS) begin
      rdata_nxt[ivc_pkg::SRC_LSB +: 2]    = src_r;
      rdata_nxt[ivc_pkg::HPF_ON_BIT]      = hpfOn_r;
      rdata_nxt[ivc_pkg::LOW_POWER_BIT]   = lowPow_r;
    end
    if (regAddr == ivc_pkg::HPF_CFG_OFS) begin
      rdata_nxt[ivc_pkg::CORNER_LSB +: 3] = corner_r;
    end
    if (regAddr == ivc_pkg::RAMP_CFG_OFS) begin
      rdata_nxt[ivc_pkg::RISE_LSB +: 3]   = riseRate_r;
      rdata_nxt[ivc_pkg::FALL_LSB +: 3]   = fallRate_r;
    end
    if (regAddr == ivc_pkg::TRIGGER_OFS) begin
      rdata_nxt[ivc_pkg::TRIG_BIT]        = trig_r;
    end
  end

  // Register and read-answer flops.
  always_ff @(posedge clk) begin
    if (rst) begin
      pendMute_r   <= {4{ivc_pkg::MUTE_RST}};
      actMute_r    <= {4{ivc_pkg::MUTE_RST}};
      pendVol_r    <= '{default: ivc_pkg::VOL_RST};
      actVol_r     <= '{default: ivc_pkg::VOL_RST};
      pga_r        <= '{default: ivc_pkg::PGA_RST};
      src_r        <= ivc_pkg::SRC_RST;
      hpfOn_r      <= 1'b0;
      lowPow_r     <= 1'b0;
      corner_r     <= ivc_pkg::CORNER_RST;
      riseRate_r   <= ivc_pkg::RAMP_RST;
      fallRate_r   <= ivc_pkg::RAMP_RST;
      trig_r       <= 1'b0;
      regRdata_r   <= 32'h0000_0000;
      regRdValid_r <= 1'b0;
    end else begin
      pendMute_r   <= pendMute_nxt;
      actMute_r    <= actMute_nxt;
      pendVol_r    <= pendVol_nxt;
      actVol_r     <= actVol_nxt;
      pga_r        <= pga_nxt;
      src_r        <= src_nxt;
      hpfOn_r      <= hpfOn_nxt;
      lowPow_r     <= lowPow_nxt;
      corner_r     <= corner_nxt;
      riseRate_r   <= riseRate_nxt;
      fallRate_r   <= fallRate_nxt;
      trig_r       <= trig_nxt;
      regRdata_r   <= regRead ? rdata_nxt : regRdata_r;
      regRdValid_r <= regRead;
    end
  end

  // Step timers; one pair shared by all channels keeps the ramps in lockstep.
  logic [19:0] cnt_r [2], cnt_nxt [2], reload [2];
  logic [1:0]  tick;
  logic [2:0]  rate [2];

  function automatic logic [19:0] stepReload(input logic [2:0] code);
    logic [19:0] r;
    case (code)
      3'h1:    r = 20'(ivc_pkg::STEP_CYC_0P5MS);
      3'h2:    r = 20'(ivc_pkg::STEP_CYC_1MS);
      3'h3:    r = 20'(ivc_pkg::STEP_CYC_2MS);
      3'h4:    r = 20'(ivc_pkg::STEP_CYC_4MS);
      3'h5:    r = 20'(STEP_CYC_8MS);
      3'h6:    r = 20'(STEP_CYC_15MS);
      3'h7:    r = 20'(STEP_CYC_30MS);
      default: r = 20'h0_0001;
    endcase
    return r;
  endfunction

  // A rate change takes hold only at the next reload, hence the host restriction.
  always_comb begin
    rate[0] = riseRate_r;
    rate[1] = fallRate_r;
    for (int d = 0; d < 2; d++) begin
      reload[d] = stepReload(rate[d]);
      tick[d]   = (cnt_r[d] == 20'h0_0000);
      if (updWr || tick[d]) begin
        cnt_nxt[d] = reload[d] - 20'h0_0001;
      end else begin
        cnt_nxt[d] = cnt_r[d] - 20'h0_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '{default: 20'h0_0000};
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // One ramp per channel, all driven by the same ticks.
  logic [9:0] rampTarget [4];
  logic [9:0] chanGain [4];

  always_comb begin
    for (int c = 0; c < 4; c++) begin
      // code to eighth-dB, reserved codes clamp
      rampTarget[c] = {((actVol_r[c] > ivc_pkg::VOL_MAX) ? ivc_pkg::VOL_MAX : actVol_r[c]),
                       2'b00};
    end
  end

  for (genvar c = 0; c < 4; c++) begin : g_ramp
    ivc_gain_ramp u_ramp (
      .clk        (clk),
      .rst        (rst),
      .targetGain (rampTarget[c]),
      .mute       (actMute_r[c]),
      .riseTick   (tick[0]),
      .fallTick   (tick[1]),
      .riseNow    (riseRate_r == 3'h0),
      .fallNow    (fallRate_r == 3'h0),
      .gain_r     (chanGain[c]),
      .silent_r   (channelSilent[c])
    );
    assign appliedGain[c*10 +: 10] = chanGain[c];
  end

  // Gain multiply: octave shift times dB and eighth-dB mantissas.
  logic [10:0]        alignGain;
  logic [4:0]         octave;
  logic [5:0]         remEighths;
  logic [31:0]        mant;
  logic signed [56:0] prod;
  logic signed [73:0] scaled;
  logic signed [73:0] shifted;
  logic [5:0]         shiftAmt;
  logic [23:0]        sampleOut_nxt;

  always_comb begin
    alignGain  = 11'(chanGain[sampleChan]) + ivc_pkg::ALIGN_OFS;
    octave     = 5'(alignGain / 11'(ivc_pkg::STEP_PER_6DB));
    remEighths = 6'(alignGain % 11'(ivc_pkg::STEP_PER_6DB));
    mant       = 32'(ivc_pkg::DB_MANT[remEighths[5:3]]) *
                 32'(ivc_pkg::EIGHTH_MANT[remEighths[2:0]]);
    prod       = 57'(sampleIn) * 57'($signed({1'b0, mant}));
    shiftAmt   = 6'(octave) + 6'(pathDigital[sampleChan[1]]);
    scaled     = 74'(prod) <<< shiftAmt;
    shifted    = scaled >>> ivc_pkg::FRAC_SHIFT;
    // Saturate rather than wrap, since wrap turns a loud peak into a full-scale click.
    if (shifted[73:23] != {51{shifted[73]}}) begin
      sampleOut_nxt = shifted[73] ? 24'h80_0000 : 24'h7F_FFFF;
    end else begin
      sampleOut_nxt = shifted[23:0];
    end
    if (channelSilent[sampleChan]) begin
      sampleOut_nxt = 24'h00_0000;
    end
  end

  // Sample stage and configuration outputs.
  logic [27:0] analogGain_nxt;

  always_comb begin
    for (int c = 0; c < 4; c++) begin
      analogGain_nxt[c*7 +: 7] = (pathMidPower[c/2] && pga_r[c] < ivc_pkg::PGA_MID_MIN) ?
                                 ivc_pkg::PGA_MID_MIN : pga_r[c];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sampleOut_r      <= 24'h00_0000;
      sampleOutValid_r <= 1'b0;
      sampleOutChan_r  <= 2'h0;
      analogGain_r     <= {4{ivc_pkg::PGA_RST}};
      p2rSource_r      <= ivc_pkg::SRC_RST;
      p2rHighpassOn_r  <= 1'b0;
      p2rLowPower_r    <= 1'b0;
      highpassCorner_r <= ivc_pkg::CORNER_RST;
      standardMode_r   <= 2'h0;
    end else begin
      sampleOut_r      <= sampleValid ? sampleOut_nxt : sampleOut_r;
      sampleOutValid_r <= sampleValid;
      sampleOutChan_r  <= sampleValid ? sampleChan : sampleOutChan_r;
      analogGain_r     <= analogGain_nxt;
      p2rSource_r      <= src_r;
      p2rHighpassOn_r  <= hpfOn_r;
      p2rLowPower_r    <= lowPow_r && !pathDigital[1];
      highpassCorner_r <= corner_r;
      // mode follows the trigger bit level on analog paths, digital paths hold
      for (int p = 0; p < 2; p++) begin
        if (pathDigital[p]) begin
          standardMode_r[p] <= standardMode_r[p];
        end else if (trig_r != trig_nxt || standardMode_r[p] != trig_r) begin
          standardMode_r[p] <= trig_nxt;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_update_applies;
    updWr |=> actVol_r[2] == $past(pendVol_nxt[2]) && actMute_r == $past(pendMute_nxt);
  endproperty
  a_update_applies: assert property (p_update_applies) else $error("update not applied");

  property p_hold_pending;
    !updWr |=> actMute_r == $past(actMute_r) && actVol_r[0] == $past(actVol_r[0]);
  endproperty
  a_hold_pending: assert property (p_hold_pending) else $error("active moved early");

  property p_update_reads_zero;
    regRead && regAddr == ivc_pkg::UPDATE_OFS |=> regRdValid_r && regRdata_r == 32'h0000_0000;
  endproperty
  a_update_reads_zero: assert property (p_update_reads_zero) else $error("update read");

  property p_std_mode_rise;
    $rose(trig_r) && !pathDigital[0] && !$past(pathDigital[0]) |-> standardMode_r[0];
  endproperty
  a_std_mode_rise: assert property (p_std_mode_rise) else $error("std mode missed");

  property p_mid_floor;
    pathMidPower[1] |=> analogGain_r[27:21] >= ivc_pkg::PGA_MID_MIN;
  endproperty
  a_mid_floor: assert property (p_mid_floor) else $error("mid-power PGA below 6 dB");

  property p_timer_align;
    updWr |=> cnt_r[0] == $past(reload[0]) - 20'h0_0001 &&
              cnt_r[1] == $past(reload[1]) - 20'h0_0001;
  endproperty
  a_timer_align: assert property (p_timer_align) else $error("timers not realigned");

  property p_rise_spacing;
    tick[0] && riseRate_r == 3'h1 && !updWr ##1 riseRate_r == 3'h1 |-> !tick[0] [*8];
  endproperty
  a_rise_spacing: assert property (p_rise_spacing) else $error("rise step too soon");

  c_update: cover property (updWr ##1 actMute_r == 4'h0);
  c_std_mode: cover property ($rose(standardMode_r[0]));
  c_sample: cover property (sampleValid && !channelSilent[sampleChan] ##1 sampleOutValid_r);

endmodule

`default_nettype wire

// >>> bench/ivc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host processor on the control port. Each request changes just after an edge.
module ivc_host_model (
  // Clock.
  input  wire logic        clk,
  // Register port.
  output logic             regWrite,
  output logic             regRead,
  output logic      [19:0] regAddr,
  output logic      [31:0] regWdata,
  input  wire logic [31:0] regRdata_r,
  input  wire logic        regRdValid_r
);
  // Idle values from time zero.
  initial begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regAddr  = 20'h0_0000;
    regWdata = 32'h0000_0000;
  end

  // Patch block, one word per address from the lowest up.
  localparam logic [31:0] PATCH_WORDS [39] = '{
    32'h4684_020F, 32'h0F05_0000, 32'h0046_2030, 32'h300F_4000, 32'h0000_4628, 32'h3030_0F40,
    32'h4000_0046, 32'h4638_300F, 32'h0F40_0000, 32'h0026_7403, 32'h010F_0F00, 32'h0000_46C4,
    32'hCC04_0F03, 32'h0900_0044, 32'h46C0_010F, 32'h0F01_0000, 32'h0046_D803, 32'h020E_0E00,
    32'h0000_4684, 32'h8402_0F01, 32'h0500_0046, 32'h46C0_010F, 32'h0F00_0000, 32'h0044_CC04,
    32'h010F_1F00, 32'h0000_46C4, 32'h7403_0F00, 32'h0000_0026, 32'h4620_300F, 32'h0F00_0000,
    32'h0046_2830, 32'h300F_0000, 32'h0000_4630, 32'h3830_0F00, 32'h0000_0046, 32'h46D8_030F,
    32'h0E00_0000, 32'h0046_8402, 32'h0000_0400};

  // One strobe per 32-bit word.
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // The data is taken at the edge that shows the valid pulse, so a lost answer reads as ones.
  task automatic rd(input logic [19:0] a, output logic [31:0] d);
    d = 32'hFFFF_FFFF;
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      if (regRdValid_r === 1'b1) begin
        d = regRdata_r;
        break;
      end
    end
  endtask

  // Standard Mode setup. The poll is bounded because this block has no such status bit.
  task automatic setup_seq();
    logic [31:0] s;
    wr(20'h0_0808, 32'h0000_0002);
    for (int i = 0; i < 4; i++) begin
      rd(20'h0_0804, s);
      if (s[1] === 1'b1) break;
    end
    wr(20'h0_0808, 32'h0000_0003);
    wr(20'h4_10AC, 32'h0000_0000);
    wr(20'h4_10B0, 32'h0000_0000);
    for (int i = 0; i < 39; i++) begin
      wr(20'h4_C800 + 20'(4 * i), PATCH_WORDS[i]);
    end
    wr(20'h4_1200, 32'h4D48_0048);
    wr(20'h0_0808, 32'h0000_0002);
    wr(20'h0_0808, 32'h0000_0000);
  endtask
endmodule

`default_nettype wire

// >>> bench/ivc_input_volume_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none

module ivc_input_volume_ctrl_tb;
  logic               clk;
  logic               rst;
  logic               regWrite;
  logic               regRead;
  logic        [19:0] regAddr;
  logic        [31:0] regWdata;
  logic        [31:0] regRdata_r;
  logic               regRdValid_r;
  logic        [1:0]  pathDigital;
  logic        [1:0]  pathMidPower;
  logic signed [23:0] sampleIn;
  logic               sampleValid;
  logic        [1:0]  sampleChan;
  logic signed [23:0] sampleOut_r;
  logic               sampleOutValid_r;
  logic        [1:0]  sampleOutChan_r;
  logic        [39:0] appliedGain;
  logic        [3:0]  channelSilent;
  logic        [27:0] analogGain_r;
  logic        [1:0]  p2rSource_r;
  logic               p2rHighpassOn_r;
  logic               p2rLowPower_r;
  logic        [2:0]  highpassCorner_r;
  logic        [1:0]  standardMode_r;
  logic        [31:0] rdat;
  int                 n_fail;
  int                 num_checks;
  int                 cycles;

  // Short step counts keep the slow ramp codes inside the run.
  ivc_input_volume_ctrl #(.STEP_CYC_8MS(20), .STEP_CYC_15MS(30), .STEP_CYC_30MS(40)) u_dut (
    .clk(clk), .rst(rst), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata_r(regRdata_r), .regRdValid_r(regRdValid_r),
    .pathDigital(pathDigital), .pathMidPower(pathMidPower), .sampleIn(sampleIn),
    .sampleValid(sampleValid), .sampleChan(sampleChan), .sampleOut_r(sampleOut_r),
    .sampleOutValid_r(sampleOutValid_r), .sampleOutChan_r(sampleOutChan_r),
    .appliedGain(appliedGain), .channelSilent(channelSilent), .analogGain_r(analogGain_r),
    .p2rSource_r(p2rSource_r), .p2rHighpassOn_r(p2rHighpassOn_r),
    .p2rLowPower_r(p2rLowPower_r), .highpassCorner_r(highpassCorner_r),
    .standardMode_r(standardMode_r));

  ivc_host_model u_host (
    .clk(clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata_r(regRdata_r), .regRdValid_r(regRdValid_r));

  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [31:0] gain(input int c);
    return 32'(appliedGain[c*10+:10]);
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // A hang counts as a failure; the whole run needs about 2300 cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic t_reset();
    u_host.rd(20'h0_4028, rdat);
    check("gain reg reset", rdat, 32'h1080_0080);
    u_host.rd(20'h0_4248, rdat);
    check("ramp reg reset", rdat, 32'h0000_0022);
    u_host.rd(20'h0_4244, rdat);
    check("corner reset", rdat, 32'h0000_0002);
    u_host.rd(20'h0_4014, rdat);
    check("update reads zero", rdat, 32'h0000_0000);
    u_host.rd(20'h0_0000, rdat);
    check("unmapped read", rdat, 32'h0000_0000);
    check("silent at reset", 32'(channelSilent), 32'h0000_000F);
  endtask

  // Values stay pending until bit 29 is written, then both channels move together.
  task automatic t_pending();
    u_host.wr(20'h0_4248, 32'h0000_0000);
    u_host.wr(20'h0_4028, 32'h0080_0080);
    u_host.wr(20'h0_4048, 32'h00BF_0080);
    u_host.wr(20'h0_4014, 32'hDFFF_FFFF);
    repeat (8) @(posedge clk);
    check("gain held", gain(0), 32'h0000_0000);
    u_host.wr(20'h0_4014, 32'h2000_0000);
    repeat (6) @(posedge clk);
    check("ch0 unity", gain(0), 32'h0000_0200);
    check("ch1 max", gain(1), 32'h0000_02FC);
    u_host.rd(20'h0_4048, rdat);
    check("ch1 readback", rdat, 32'h00BF_0080);
  endtask

  task automatic t_sample(input logic [1:0] ch, input logic [23:0] exp);
    @(posedge clk);
    sampleValid <= 1'b1;
    sampleChan  <= ch;
    sampleIn    <= 24'h00_03E8;
    @(posedge clk);
    sampleValid <= 1'b0;
    @(posedge clk);
    check("sample valid", 32'(sampleOutValid_r), 32'h0000_0001);
    check("sample chan", 32'(sampleOutChan_r), 32'(ch));
    check("sample out", {8'h00, sampleOut_r}, {8'h00, exp});
  endtask

  task automatic t_ramp();
    u_host.wr(20'h0_4028, 32'h1080_0080);
    u_host.wr(20'h0_4014, 32'h2000_0000);
    repeat (6) @(posedge clk);
    check("mute jump", gain(0), 32'h0000_0000);
    check("ch0 silent", 32'(channelSilent[0]), 32'h0000_0001);
    u_host.wr(20'h0_4248, 32'h0000_0011);
    u_host.wr(20'h0_4048, 32'h00BE_0080);
    u_host.wr(20'h0_4014, 32'h2000_0000);
    repeat (200) @(posedge clk);
    check("before first step", gain(1), 32'h0000_02FC);
    repeat (400) @(posedge clk);
    check("one eighth dB", gain(1), 32'h0000_02FB);
    repeat (1400) @(posedge clk);
    check("ramp end", gain(1), 32'h0000_02F8);
    // Slow fall code set while idle.
    u_host.wr(20'h0_4248, 32'h0000_0051);
    u_host.wr(20'h0_4048, 32'h10BE_0080);
    u_host.wr(20'h0_4014, 32'h2000_0000);
    repeat (50) @(posedge clk);
    check("mute fade", gain(1), 32'h0000_02F6);
    repeat (40) @(posedge clk);
    check("mute fade on", gain(1), 32'h0000_02F4);
  endtask

  task automatic t_config();
    u_host.wr(20'h0_4084, 32'h1000_0005);
    u_host.wr(20'h0_4244, 32'h0000_0004);
    u_host.wr(20'h0_4068, 32'h1080_0084);
    repeat (3) @(posedge clk);
    check("source", 32'(p2rSource_r), 32'h0000_0001);
    check("hpf on", 32'(p2rHighpassOn_r), 32'h0000_0001);
    check("low power", 32'(p2rLowPower_r), 32'h0000_0001);
    check("corner", 32'(highpassCorner_r), 32'h0000_0004);
    check("pga", 32'(analogGain_r[14+:7]), 32'h0000_0042);
    pathMidPower <= 2'b10;
    pathDigital  <= 2'b10;
    repeat (3) @(posedge clk);
    check("pga floor", 32'(analogGain_r[14+:7]), 32'h0000_0046);
    check("lp digital", 32'(p2rLowPower_r), 32'h0000_0000);
    u_host.wr(20'h0_4068, 32'h1080_008E);
    repeat (3) @(posedge clk);
    check("pga above", 32'(analogGain_r[14+:7]), 32'h0000_0047);
    pathMidPower <= 2'b00;
  endtask

  task automatic t_mode();
    u_host.setup_seq();
    u_host.wr(20'h1_9000, 32'h0000_0001);
    repeat (4) @(posedge clk);
    check("std digital hold", 32'(standardMode_r), 32'h0000_0001);
    pathDigital <= 2'b00;
    u_host.wr(20'h1_9000, 32'h0000_0000);
    repeat (4) @(posedge clk);
    check("back to high perf", 32'(standardMode_r), 32'h0000_0000);
    u_host.wr(20'h1_9000, 32'h0000_0001);
    repeat (4) @(posedge clk);
    check("std both", 32'(standardMode_r), 32'h0000_0003);
  endtask

  // Main sequence after a 12-cycle reset.
  initial begin
    n_fail       = 0;
    num_checks   = 0;
    cycles       = 0;
    rst          = 1'b1;
    pathDigital  = 2'b00;
    pathMidPower = 2'b00;
    sampleIn     = 24'h00_0000;
    sampleValid  = 1'b0;
    sampleChan   = 2'b00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_pending();
    pathDigital <= 2'b01;
    t_sample(2'b00, 24'h00_07D0);
    t_sample(2'b10, 24'h00_0000);
    t_ramp();
    t_config();
    t_mode();
    report_and_stop();
  end
endmodule

`default_nettype wire
